// ---- vsc_host.sv ----
// Host controller that addresses and selects volumes on a shared target select line.
module vsc_host import vsc_pkg::*; #(
    parameter int VOL_W = 4,
    parameter bit CRA_SUPPORTED = 1'b1,
    parameter bit RDO_SUPPORTED = 1'b1
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic stepValid,
    input wire logic [2:0] stepKind,
    input wire logic [7:0] stepByte,
    input wire logic [VOL_W-1:0] stepVolume,
    input wire logic fastIface,
    output logic stepAck,
    output logic stepError,
    output logic [7:0] readData,
    output logic readValid,
    output logic ceN,
    output logic cle,
    output logic ale,
    output logic weN,
    output logic reN,
    output logic [7:0] dqOut,
    output logic dqOe,
    input wire logic [7:0] dqIn,
    output logic [(1<<VOL_W)-1:0] appointedMask,
    output logic [(1<<VOL_W)-1:0] suspendedIn,
    output logic [(1<<VOL_W)-1:0] suspendedOut
);
    localparam int NV = 1 << VOL_W;

    typedef enum logic [10:0] {
        S_IDLE = 11'h001, S_STRB = 11'h002, S_HOLD = 11'h004, S_DONE = 11'h008,
        S_APP = 11'h010, S_FEAT = 11'h020, S_CEH = 11'h040, S_VSA = 11'h080,
        S_VSDONE = 11'h100, S_CCS = 11'h200, S_FAST = 11'h400
    } vsc_state_e;

    // ****************************************
    // Sequence classification
    // ****************************************
    function automatic vsc_seq_e seqAfterCmd(input vsc_seq_e seq, input logic [7:0] op);
        vsc_seq_e r;
        r = seq;
        case (op)
            OP_READ: r = Q_READ;
            OP_READ_END0, OP_READ_END1, OP_READ_END2, OP_READ_END3: r = Q_NONE;
            OP_PROG0, OP_PROG1, OP_CHANGE_ROW: r = Q_PROG;
            OP_PROG_END0, OP_PROG_END1, OP_PROG_END2: r = Q_NONE;
            OP_ERASE: r = Q_ERASE;
            OP_ERASE_END0, OP_ERASE_END1: r = Q_NONE;
            OP_SET_FEAT, OP_GET_FEAT: r = Q_FEAT;
            default: r = (seq == Q_FEAT) ? Q_NONE : seq;
        endcase
        return r;
    endfunction : seqAfterCmd

    vsc_state_e state, next_state, retState, next_retState;
    vsc_seq_e seq, next_seq;
    logic [2:0] busKind, next_busKind;
    logic [7:0] busByte, next_busByte;
    logic [2:0] appCnt, next_appCnt;
    logic [2:0] featCnt, next_featCnt;
    logic [VOL_W-1:0] curVol, next_curVol;
    logic [VOL_W-1:0] tgtVol, next_tgtVol;
    logic selValid, next_selValid;
    logic dinSeen, next_dinSeen;
    logic outActive, next_outActive;
    logic next_stepAck, next_stepError, next_readValid;
    logic [7:0] next_readData;
    logic next_ceN, next_cle, next_ale, next_weN, next_reN, next_dqOe;
    logic [7:0] next_dqOut;
    logic [NV-1:0] next_appointedMask, next_suspendedIn, next_suspendedOut;
    logic tmrLoad;
    logic [TMR_W-1:0] tmrCount;
    logic tmrDone;
    logic switching;

    vsc_timer u_timer (
        .clk(clk),
        .reset_n(reset_n),
        .load(tmrLoad),
        .loadCount(tmrCount),
        .done(tmrDone)
    );

    assign switching = !selValid || (stepVolume != curVol);

    // ****************************************
    // Next-state logic
    // ****************************************
    always_comb begin
        next_state = state;
        next_retState = retState;
        next_seq = seq;
        next_busKind = busKind;
        next_busByte = busByte;
        next_appCnt = appCnt;
        next_featCnt = featCnt;
        next_curVol = curVol;
        next_tgtVol = tgtVol;
        next_selValid = selValid;
        next_dinSeen = dinSeen;
        next_outActive = outActive;
        next_stepAck = 1'b0;
        next_stepError = 1'b0;
        next_readValid = 1'b0;
        next_readData = readData;
        next_ceN = ceN;
        next_cle = cle;
        next_ale = ale;
        next_weN = weN;
        next_reN = reN;
        next_dqOut = dqOut;
        next_dqOe = dqOe;
        next_appointedMask = appointedMask;
        next_suspendedIn = suspendedIn;
        next_suspendedOut = suspendedOut;
        tmrLoad = 1'b0;
        tmrCount = '0;
        case (state)
            S_IDLE: begin
                if (stepValid && !stepAck) begin
                    next_tgtVol = stepVolume;
                    if (ceN && !(stepKind == K_CMD && switching && selValid)) begin
                        next_ceN = 1'b0;
                    end else if (stepKind == K_APPOINT) begin
                        // An address already handed out is refused, so no two targets share it.
                        next_stepError = appointedMask[stepVolume];
                        next_stepAck = appointedMask[stepVolume];
                        next_appCnt = '0;
                        next_state = appointedMask[stepVolume] ? S_IDLE : S_APP;
                    end else if (switching) begin
                        // Only a command may open a new volume; atomic sequences stay whole.
                        if (!appointedMask[stepVolume] || stepKind != K_CMD) begin
                            next_stepError = 1'b1;
                            next_stepAck = 1'b1;
                        end else if (seq == Q_READ || seq == Q_ERASE || seq == Q_FEAT) begin
                            next_stepError = 1'b1;
                            next_stepAck = 1'b1;
                        end else if (seq == Q_PROG && (!dinSeen || !CRA_SUPPORTED)) begin
                            next_stepError = 1'b1;
                            next_stepAck = 1'b1;
                        end else if (outActive && !RDO_SUPPORTED) begin
                            next_stepError = 1'b1;
                            next_stepAck = 1'b1;
                        end else begin
                            if (selValid && seq == Q_PROG) begin
                                next_suspendedIn[curVol] = 1'b1;
                            end
                            if (selValid && outActive) begin
                                next_suspendedOut[curVol] = 1'b1;
                            end
                            if (selValid && seq == Q_PROG && fastIface) begin
                                next_busKind = K_CMD;
                                next_busByte = OP_PROG_END1;
                                next_retState = S_FAST;
                                next_state = S_STRB;
                            end else begin
                                next_ceN = 1'b1;
                                tmrLoad = 1'b1;
                                tmrCount = SELECT_HIGH_CYC;
                                next_state = S_CEH;
                            end
                        end
                    end else if ((suspendedIn[curVol] && (stepKind != K_CMD
                            || stepByte != OP_CHANGE_ROW))
                            || (stepKind == K_DOUT && suspendedOut[curVol])) begin
                        next_stepError = 1'b1;
                        next_stepAck = 1'b1;
                    end else begin
                        // Same volume: no further Volume Select is sent.
                        next_busKind = stepKind;
                        next_busByte = stepByte;
                        next_retState = S_DONE;
                        next_state = S_STRB;
                        if (stepKind == K_CMD) begin
                            next_seq = seqAfterCmd(seq, stepByte);
                            next_dinSeen = 1'b0;
                            next_outActive = 1'b0;
                            next_featCnt = '0;
                            if (stepByte == OP_CHANGE_ROW) begin
                                next_suspendedIn[curVol] = 1'b0;
                            end
                            if (stepByte == OP_RANDOM_OUT || stepByte == OP_COL_ENH) begin
                                next_suspendedOut[curVol] = 1'b0;
                            end
                        end else if (stepKind == K_DIN || stepKind == K_DOUT) begin
                            next_dinSeen = dinSeen || stepKind == K_DIN;
                            next_outActive = outActive || stepKind == K_DOUT;
                            if (seq == Q_FEAT) begin
                                next_featCnt = featCnt + 3'h1;
                                if (featCnt + 3'h1 == FEAT_BYTES) begin
                                    next_seq = Q_NONE;
                                end
                            end
                        end
                    end
                end
            end
            S_STRB: begin
                next_cle = busKind == K_CMD;
                next_ale = busKind == K_ADDR;
                next_weN = busKind == K_DOUT;
                next_reN = busKind != K_DOUT;
                next_dqOe = busKind != K_DOUT;
                next_dqOut = busByte;
                next_state = S_HOLD;
            end
            S_HOLD: begin
                next_weN = 1'b1;
                next_reN = 1'b1;
                if (busKind == K_DOUT) begin
                    next_readData = dqIn;
                    next_readValid = 1'b1;
                end
                next_state = retState;
            end
            S_DONE: begin
                next_cle = 1'b0;
                next_ale = 1'b0;
                next_dqOe = 1'b0;
                next_stepAck = 1'b1;
                next_state = S_IDLE;
            end
            S_APP: begin
                // Feature write carrying the volume address in its first parameter.
                next_appCnt = appCnt + 3'h1;
                next_retState = S_APP;
                next_state = S_STRB;
                next_busKind = (appCnt == 3'h0) ? K_CMD : (appCnt == 3'h1) ? K_ADDR : K_DIN;
                next_busByte = (appCnt == 3'h0) ? OP_SET_FEAT : (appCnt == 3'h1) ? FA_VOLUME_CFG
                    : (appCnt == 3'h2) ? 8'(tgtVol) : 8'h00;
                if (appCnt > APPOINT_LAST) begin
                    next_cle = 1'b0;
                    next_ale = 1'b0;
                    next_dqOe = 1'b0;
                    tmrLoad = 1'b1;
                    tmrCount = FEATURE_BUSY_CYC;
                    next_state = S_FEAT;
                end
            end
            S_FEAT: begin
                if (tmrDone) begin
                    next_appointedMask[tgtVol] = 1'b1;
                    next_selValid = 1'b0;
                    next_seq = Q_NONE;
                    next_stepAck = 1'b1;
                    next_state = S_IDLE;
                end
            end
            S_FAST: begin
                next_cle = 1'b0;
                next_dqOe = 1'b0;
                next_ceN = 1'b1;
                tmrLoad = 1'b1;
                tmrCount = SELECT_HIGH_CYC;
                next_state = S_CEH;
            end
            S_CEH: begin
                if (tmrDone) begin
                    next_ceN = 1'b0;
                    next_busKind = K_CMD;
                    next_busByte = OP_VOL_SELECT;
                    next_retState = S_VSA;
                    next_state = S_STRB;
                end
            end
            S_VSA: begin
                next_busKind = K_ADDR;
                next_busByte = 8'(tgtVol);
                next_retState = S_VSDONE;
                next_state = S_STRB;
            end
            S_VSDONE: begin
                next_cle = 1'b0;
                next_ale = 1'b0;
                next_dqOe = 1'b0;
                next_curVol = tgtVol;
                next_selValid = 1'b1;
                next_seq = Q_NONE;
                next_dinSeen = 1'b0;
                next_outActive = 1'b0;
                next_state = S_IDLE;
                if (suspendedIn[tgtVol]) begin
                    tmrLoad = 1'b1;
                    tmrCount = CHANGE_SETUP_CYC;
                    next_state = S_CCS;
                end
            end
            S_CCS: begin
                if (tmrDone) begin
                    next_state = S_IDLE;
                end
            end
            default: begin
                next_state = S_IDLE;
            end
        endcase
    end

    // ****************************************
    // State registers
    // ****************************************
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            state <= S_IDLE;
            retState <= S_IDLE;
            seq <= Q_NONE;
            busKind <= K_CMD;
            busByte <= 8'h00;
            appCnt <= 3'h0;
            featCnt <= 3'h0;
            curVol <= '0;
            tgtVol <= '0;
            selValid <= 1'b0;
            dinSeen <= 1'b0;
            outActive <= 1'b0;
            stepAck <= 1'b0;
            stepError <= 1'b0;
            readValid <= 1'b0;
            readData <= 8'h00;
            ceN <= 1'b1;
            cle <= 1'b0;
            ale <= 1'b0;
            weN <= 1'b1;
            reN <= 1'b1;
            dqOut <= 8'h00;
            dqOe <= 1'b0;
            appointedMask <= '0;
            suspendedIn <= '0;
            suspendedOut <= '0;
        end else begin
            state <= next_state;
            retState <= next_retState;
            seq <= next_seq;
            busKind <= next_busKind;
            busByte <= next_busByte;
            appCnt <= next_appCnt;
            featCnt <= next_featCnt;
            curVol <= next_curVol;
            tgtVol <= next_tgtVol;
            selValid <= next_selValid;
            dinSeen <= next_dinSeen;
            outActive <= next_outActive;
            stepAck <= next_stepAck;
            stepError <= next_stepError;
            readValid <= next_readValid;
            readData <= next_readData;
            ceN <= next_ceN;
            cle <= next_cle;
            ale <= next_ale;
            weN <= next_weN;
            reN <= next_reN;
            dqOut <= next_dqOut;
            dqOe <= next_dqOe;
            appointedMask <= next_appointedMask;
            suspendedIn <= next_suspendedIn;
            suspendedOut <= next_suspendedOut;
        end
    end
endmodule : vsc_host

// ---- vsc_pkg.sv ----
// Constants shared by the volume select controller.
package vsc_pkg;
    // ****************************************
    // Timing
    // ****************************************
    localparam int CLK_PERIOD_NS = 10;
    localparam int SELECT_HIGH_TIME_NS = 20;
    localparam int CHANGE_SETUP_TIME_NS = 300;
    localparam int FEATURE_BUSY_TIME_NS = 1000;
    localparam int TMR_W = 16;
    localparam logic [TMR_W-1:0] SELECT_HIGH_CYC =
        TMR_W'((SELECT_HIGH_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [TMR_W-1:0] CHANGE_SETUP_CYC =
        TMR_W'((CHANGE_SETUP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [TMR_W-1:0] FEATURE_BUSY_CYC =
        TMR_W'((FEATURE_BUSY_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    // ****************************************
    // Opcodes and feature address
    // ****************************************
    localparam logic [7:0] OP_READ = 8'h00;
    localparam logic [7:0] OP_READ_END0 = 8'h30;
    localparam logic [7:0] OP_READ_END1 = 8'h31;
    localparam logic [7:0] OP_READ_END2 = 8'h32;
    localparam logic [7:0] OP_READ_END3 = 8'h35;
    localparam logic [7:0] OP_PROG0 = 8'h80;
    localparam logic [7:0] OP_PROG1 = 8'h81;
    localparam logic [7:0] OP_CHANGE_ROW = 8'h85;
    localparam logic [7:0] OP_PROG_END0 = 8'h10;
    localparam logic [7:0] OP_PROG_END1 = 8'h11;
    localparam logic [7:0] OP_PROG_END2 = 8'h15;
    localparam logic [7:0] OP_ERASE = 8'h60;
    localparam logic [7:0] OP_ERASE_END0 = 8'hd0;
    localparam logic [7:0] OP_ERASE_END1 = 8'hd1;
    localparam logic [7:0] OP_RANDOM_OUT = 8'h05;
    localparam logic [7:0] OP_COL_ENH = 8'h06;
    localparam logic [7:0] OP_SET_FEAT = 8'hef;
    localparam logic [7:0] OP_GET_FEAT = 8'hee;
    localparam logic [7:0] OP_VOL_SELECT = 8'he1;
    localparam logic [7:0] FA_VOLUME_CFG = 8'h58;
    localparam logic [2:0] FEAT_BYTES = 3'h4;
    localparam logic [2:0] APPOINT_LAST = 3'h5;
    // ****************************************
    // Step kinds and sequence tracking
    // ****************************************
    typedef enum logic [2:0] {
        K_CMD = 3'h0, K_ADDR = 3'h1, K_DIN = 3'h2, K_DOUT = 3'h3, K_APPOINT = 3'h4
    } vsc_kind_e;
    typedef enum logic [4:0] {
        Q_NONE = 5'h01, Q_READ = 5'h02, Q_PROG = 5'h04, Q_ERASE = 5'h08, Q_FEAT = 5'h10
    } vsc_seq_e;
endpackage : vsc_pkg

// ---- vsc_timer.sv ----
// Down counter that times the select, setup and feature waits.
module vsc_timer import vsc_pkg::*; (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic load,
    input wire logic [TMR_W-1:0] loadCount,
    output logic done
);
    logic [TMR_W-1:0] count;
    logic [TMR_W-1:0] next_count;

    always_comb begin
        next_count = count;
        if (load) begin
            next_count = loadCount;
        end else if (count != '0) begin
            next_count = count - TMR_W'(1);
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            count <= '0;
        end else begin
            count <= next_count;
        end
    end

    assign done = count <= TMR_W'(1);
endmodule : vsc_timer

// ---- vsc_dev_model.sv ----
// Behavioural flash targets that answer the volume select controller.
module vsc_dev_model import vsc_pkg::*; (
    input wire logic clk,
    input wire logic ceN,
    input wire logic cle,
    input wire logic ale,
    input wire logic weN,
    input wire logic reN,
    input wire logic [7:0] dqOut,
    output logic [7:0] dqIn,
    output logic [7:0] lastByte,
    output logic [7:0] preSelCmd,
    output logic chainOut
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [7:0] cmd = 8'h00;
    logic [3:0] selVol = 4'h0;
    logic [3:0] ownVol = 4'h0;
    logic [2:0] n = 3'h0;
    logic weQ = 1'b1;
    logic revert = 1'b0;
    // ****************************************
    // Bus decode
    // ****************************************
    // A released bus shows the inverse of the read byte {4'h5, selVol}.
    assign dqIn = reN ? ~{4'h5, selVol} : {4'h5, selVol};
    // Raising select enters reversion at once; a first command other than a select leaves it.
    always @(posedge clk or posedge ceN) begin
        if (ceN) begin
            revert <= 1'b1;
        end else if (weN && !weQ && ((cle && dqOut != OP_VOL_SELECT)
                || (ale && cmd == OP_VOL_SELECT))) begin
            revert <= 1'b0;
        end
    end
    always @(posedge clk) begin
        weQ <= weN;
        if (!ceN && weN && !weQ) begin
            lastByte <= dqOut;
            if (cle) begin
                cmd <= dqOut;
                n <= 3'h0;
                if (dqOut == OP_VOL_SELECT && revert) preSelCmd <= cmd;
            end else if (ale && cmd == OP_VOL_SELECT) begin
                selVol <= dqOut[3:0];
            end else begin
                n <= n + 3'h1;
                if (cmd == OP_SET_FEAT && n == 3'h1) begin
                    ownVol <= dqOut[3:0];
                    chainOut <= 1'b1;
                end
            end
        end
    end
endmodule : vsc_dev_model

// ---- vsc_host_chk.sv ----
// Port checks for the volume select controller.
module vsc_host_chk import vsc_pkg::*; #(
    parameter int VOL_W = 4
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic [2:0] stepKind,
    input wire logic [VOL_W-1:0] stepVolume,
    input wire logic stepAck,
    input wire logic stepError,
    input wire logic readValid,
    input wire logic ceN,
    input wire logic cle,
    input wire logic ale,
    input wire logic weN,
    input wire logic reN,
    input wire logic [7:0] dqOut,
    input wire logic dqOe,
    input wire logic [(1<<VOL_W)-1:0] appointedMask
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [TMR_W-1:0] quietCnt;
    logic [TMR_W-1:0] next_quietCnt;
    // ****************************************
    // Strobe quiet counter and properties
    // ****************************************
    always_comb begin
        next_quietCnt = quietCnt;
        if (!reset_n || !weN) next_quietCnt = {TMR_W{1'b0}};
        else if (quietCnt != {TMR_W{1'b1}}) next_quietCnt = quietCnt + 1'b1;
    end
    always_ff @(posedge clk) quietCnt <= next_quietCnt;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    sequence s_sel_cmd;
        cle && $rose(weN) && dqOut == OP_VOL_SELECT;
    endsequence
    sequence s_vol_addr;
        ale && !weN && dqOut[VOL_W-1:0] == stepVolume;
    endsequence
    a_reset_quiet: assert property ($rose(reset_n) |-> ceN && weN && reN && !(|appointedMask))
        else $error("pins not idle after reset");
    a_ack_pulse: assert property (stepAck |=> !stepAck) else $error("ack too long");
    a_err_with_ack: assert property (stepError |-> stepAck) else $error("error without ack");
    a_read_then_ack: assert property (readValid |=> stepAck && !readValid)
        else $error("read data not followed by ack");
    a_read_bus_free: assert property (!reN |-> !dqOe && !cle && !ale && weN)
        else $error("bus driven during read strobe");
    a_write_held: assert property ($fell(weN) |=> weN && dqOe && $stable(dqOut) && !ceN)
        else $error("byte not held over write strobe");
    a_ce_high_min: assert property ($rose(ceN) |-> ceN [*2])
        else $error("select high too short");
    a_sel_addr: assert property (s_sel_cmd |-> ##[1:6] s_vol_addr)
        else $error("volume select without volume address");
    a_feat_busy: assert property (stepAck && !stepError && $past(stepKind) == 3'h4 |->
        quietCnt >= FEATURE_BUSY_CYC) else $error("appoint ack too early");
endmodule : vsc_host_chk

// ---- vsc_host_tb_top.sv ----
// Self-checking bench for the volume select controller.
module vsc_host_tb_top import vsc_pkg::*; ();
    timeunit 1ns;
    timeprecision 100ps;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic stepValid = 1'b0;
    logic [2:0] stepKind = 3'h0;
    logic [7:0] stepByte = 8'h00;
    logic [3:0] stepVolume = 4'h0;
    logic fastIface = 1'b0;
    logic stepAck, stepError, readValid, ceN, cle, ale, weN, reN, dqOe, chainOut;
    logic [7:0] readData, dqOut, dqIn, lastByte, preSelCmd, rd;
    logic [15:0] appointedMask, suspendedIn, suspendedOut;
    logic [7:0] rdEnd [4] = '{OP_READ_END0, OP_READ_END1, OP_READ_END2, OP_READ_END3};
    logic [7:0] erEnd [2] = '{OP_ERASE_END0, OP_ERASE_END1};
    int nMismatch = 0;
    int checked = 0;
    int cyc;
    logic [31:0] r;
    logic [3:0] v;
    // ****************************************
    // Harness, tasks and tests
    // ****************************************
    vsc_host u_vsc_host (.clk, .reset_n, .stepValid, .stepKind, .stepByte, .stepVolume,
        .fastIface, .stepAck, .stepError, .readData, .readValid, .ceN, .cle, .ale, .weN,
        .reN, .dqOut, .dqOe, .dqIn, .appointedMask, .suspendedIn, .suspendedOut);
    vsc_dev_model u_vsc_dev_model (.clk, .ceN, .cle, .ale, .weN, .reN, .dqOut, .dqIn,
        .lastByte, .preSelCmd, .chainOut);
    always #5 clk = ~clk;
    function automatic logic [7:0] rdExp(input logic [3:0] vol);
        return {4'h5, vol};
    endfunction : rdExp
    function automatic logic [15:0] bitOf(input logic [3:0] vol);
        return 16'h0001 << vol;
    endfunction : bitOf
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            nMismatch++;
            $display("[FAIL] %0t got %h want %h", $time, seen, exp);
        end
    endtask : check
    task automatic step(input logic [2:0] k, input logic [7:0] b, input logic [3:0] vol,
        input logic e);
        stepKind = k;
        stepByte = b;
        stepVolume = vol;
        stepValid = 1'b1;
        rd = 8'hxx;
        cyc = 0;
        do begin
            @(posedge clk);
            #1;
            cyc++;
            if (readValid === 1'b1) rd = readData;
        end while (stepAck !== 1'b1 && cyc < 400);
        if (cyc >= 400) nMismatch++;
        check(stepError, e);
    endtask : step
    task automatic results();
        $display("mismatches %0d checks %0d", nMismatch, checked);
        if (nMismatch == 0 && checked > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : results
    initial begin
        r = $urandom(88917);
        repeat (5) @(posedge clk);
        #1;
        reset_n = 1'b1;
        check(ceN, 1'b1);
        @(posedge clk);
        #1;
        step(3'h0, OP_READ, 4'h1, 1'b1);
        step(3'h4, 8'h00, 4'h1, 1'b0);
        check(16'(cyc >= 112), 16'h0001);
        check(chainOut, 1'b1);
        step(3'h4, 8'h00, 4'h2, 1'b0);
        check(appointedMask, 16'h0006);
        step(3'h4, 8'h00, 4'h2, 1'b1);
        foreach (rdEnd[i]) begin
            step(3'h0, OP_READ, 4'h1, 1'b0);
            step(3'h1, 8'(i), 4'h1, 1'b0);
            step(3'h0, OP_READ, 4'h2, 1'b1);
            step(3'h0, rdEnd[i], 4'h1, 1'b0);
            step(3'h3, 8'h00, 4'h1, 1'b0);
            check(rd, rdExp(4'h1));
        end
        foreach (erEnd[i]) begin
            step(3'h0, OP_ERASE, 4'h1, 1'b0);
            step(3'h1, 8'(i), 4'h1, 1'b0);
            step(3'h0, OP_READ, 4'h2, 1'b1);
            step(3'h0, erEnd[i], 4'h1, 1'b0);
        end
        step(3'h0, OP_GET_FEAT, 4'h1, 1'b0);
        step(3'h1, FA_VOLUME_CFG, 4'h1, 1'b0);
        step(3'h0, OP_READ, 4'h2, 1'b1);
        repeat (4) step(3'h3, 8'h00, 4'h1, 1'b0);
        step(3'h0, OP_PROG1, 4'h2, 1'b0);
        check(suspendedOut, bitOf(4'h1));
        step(3'h1, 8'h00, 4'h2, 1'b0);
        step(3'h0, 8'h70, 4'h1, 1'b1);
        r = $urandom;
        step(3'h2, r[7:0], 4'h2, 1'b0);
        check(lastByte, r[7:0]);
        fastIface = 1'b1;
        step(3'h0, 8'h70, 4'h1, 1'b0);
        check(preSelCmd, OP_PROG_END1);
        check(suspendedIn, bitOf(4'h2));
        step(3'h3, 8'h00, 4'h1, 1'b1);
        step(3'h0, OP_COL_ENH, 4'h1, 1'b0);
        step(3'h3, 8'h00, 4'h1, 1'b0);
        check(rd, rdExp(4'h1));
        step(3'h0, 8'h70, 4'h2, 1'b1);
        check(16'(cyc >= CHANGE_SETUP_CYC), 16'h0001);
        step(3'h2, r[15:8], 4'h2, 1'b1);
        step(3'h0, OP_CHANGE_ROW, 4'h2, 1'b0);
        step(3'h1, 8'h00, 4'h2, 1'b0);
        step(3'h2, r[15:8], 4'h2, 1'b0);
        step(3'h0, OP_PROG_END0, 4'h2, 1'b0);
        check(suspendedIn, 16'h0000);
        for (int j = 0; j < 30; j++) begin
            r = $urandom;
            v = 4'h1 + 4'(r[0]);
            fastIface = r[1];
            step(3'h0, r[2] ? OP_COL_ENH : OP_RANDOM_OUT, v, 1'b0);
            step(3'h3, 8'h00, v, 1'b0);
            check(rd, rdExp(v));
            step(3'h1, r[15:8], v, 1'b0);
            check(lastByte, r[15:8]);
        end
        stepValid = 1'b0;
        reset_n = 1'b0;
        repeat (2) @(posedge clk);
        #1;
        reset_n = 1'b1;
        check(appointedMask, 16'h0000);
        @(posedge clk);
        #1;
        step(3'h0, OP_READ, 4'h1, 1'b1);
        stepValid = 1'b0;
        results();
    end
    initial begin
        #500000;
        nMismatch++;
        results();
    end
endmodule : vsc_host_tb_top
bind vsc_host vsc_host_chk #(.VOL_W(VOL_W)) u_vsc_host_chk (.clk, .reset_n, .stepKind,
    .stepVolume, .stepAck, .stepError, .readValid, .ceN, .cle, .ale, .weN, .reN, .dqOut,
    .dqOe, .appointedMask);
